// ==== rtl/ptsc_counters.sv ====
// Operation
// [R1] Count tx drops: underflow, or MAC error not counted as late/excess collision.
// [R2] Add bytes of good tx packets, FCS included, into 64-bit total.
// [R3] Count good tx broadcast packets only.
// [R4] Count good tx multicast packets only, excluding broadcast.
// [R5] Count good tx unicast packets per port.
// [R6] Add every collision seen while transmitting to collision total.
// [R7] Successful packet: one collision to single, more to multiple counter.
// [R8] Count deferred first attempts, half duplex only.
// [R9] Count each collision later than 512 bit-times.
// [R10] Count packets abandoned after 16 attempts.
// [R11] Count PAUSE events generated per port.
// [R12] Count queue-full forwarding discards in congestion page slot; the code counts them in each port's own window slot IX_QFULL.
// [R13] With QoS on, six class counters for the queue-selected port.
// [R14] Bin all packets by length into six size counters; the code bins only lengths 64 to MAX_STD_LEN.
// [R15] Asymmetric mode: count low-power request assertions.
// [R16] Symmetric mode: count simultaneous tx request and rx indication.
// [R17] Accumulate low-power idle time in microseconds.
// [R18] Give each port a window of 45 counter slots.
// [R19] Histogram direction selectable per port, receive or transmit.
// [R20] Status word type selects receive or transmit counters.
// [R21] Snapshot a selected port's counters while live ones keep counting.
// [R22] Every counter wraps independently at its width.
`timescale 1ns/1ps
`default_nettype none
module ptsc_counters
   import ptsc_pkg::*;
#(
   parameter int          NUM_PORTS   = 6,
   parameter logic [13:0] MAX_STD_LEN = 14'd1518
) (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic [15:0]          avs_address_i,
   input  wire logic                 avs_read_i,
   input  wire logic                 avs_write_i,
   input  wire logic [31:0]          avs_writedata_i,
   input  wire logic [3:0]           avs_byteenable_i,
   output logic      [31:0]          avs_readdata_o,
   output logic                      avs_waitrequest_o,
   input  wire logic                 st_valid_i,
   input  wire logic [PORT_W-1:0]    st_port_i,
   input  wire logic                 st_is_tx_i,
   input  wire logic [LEN_W-1:0]     st_length_i,
   input  wire logic                 st_good_i,
   input  wire logic                 st_bcast_i,
   input  wire logic                 st_mcast_i,
   input  wire logic [COLL_W-1:0]    st_coll_cnt_i,
   input  wire logic                 st_late_coll_i,
   input  wire logic                 st_excess_coll_i,
   input  wire logic                 st_deferred_i,
   input  wire logic                 st_half_duplex_i,
   input  wire logic                 st_underflow_i,
   input  wire logic                 st_mac_err_i,
   input  wire logic                 st_pause_i,
   input  wire logic [2:0]           st_cos_i,
   input  wire logic [NUM_PORTS-1:0] queue_full_discard_i,
   input  wire logic [NUM_PORTS-1:0] tx_low_power_request_i,
   input  wire logic [NUM_PORTS-1:0] rx_low_power_indication_i
);

   function automatic logic [31:0] slot_read(input logic [CNT_N-1:0][31:0] row,
                                             input logic [63:0] bytes, input logic [5:0] ix);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (ix == 6'(IX_BYTES_LO)) begin
         v = bytes[31:0];
      end else if (ix == 6'(IX_BYTES_HI)) begin
         v = bytes[63:32];
      end else if (ix < 6'(CNT_N)) begin
         v = row[ix[4:0]];
      end
      return v;
   endfunction

   logic [CNT_N-1:0][31:0]  cnt_q   [NUM_PORTS];
   logic [63:0]             bytes_q [NUM_PORTS];
   logic [31:0]             inc     [NUM_PORTS][CNT_N];
   logic [31:0]             byte_inc [NUM_PORTS];
   logic [31:0]             class_q [NUM_CLASSES];
   logic [CNT_N-1:0][31:0]  snap_q;
   logic [63:0]             snap_bytes_q;
   logic [PORT_W-1:0]       snap_port_q;
   logic [PORT_W-1:0]       qsel_q;
   logic                    qos_q;
   logic                    sym_q;
   logic [NUM_PORTS-1:0]    hist_tx_q;
   logic [NUM_PORTS-1:0]    lp_prev_q;
   logic [US_W-1:0]         us_cnt_q;
   logic                    wait_q;
   logic [31:0]             rdata_q;

   // Status decode
   wire                   tx_st       = st_valid_i & st_is_tx_i;
   wire                   tx_good     = tx_st & st_good_i;
   wire                   coll_any    = st_coll_cnt_i != '0;
   wire                   coll_one    = st_coll_cnt_i == 5'h01;
   wire                   ok_sent     = tx_good & ~st_excess_coll_i;
   wire                   drop_ev     = tx_st & (st_underflow_i |
                                        (st_mac_err_i & ~st_late_coll_i & ~st_excess_coll_i));
   wire                   hist_sel    = st_valid_i & (st_is_tx_i == hist_tx_q[st_port_i]);
   wire [NUM_BINS-1:0]    bin_hit;
   wire                   us_tick     = us_cnt_q == US_W'(US_CYCLES - 1);
   wire [NUM_PORTS-1:0]   lp_state    = sym_q ? (tx_low_power_request_i & rx_low_power_indication_i)
                                              : tx_low_power_request_i;
   wire [NUM_PORTS-1:0]   lp_rise     = lp_state & ~lp_prev_q;

   // [R14] Length bins
   assign bin_hit[0] = st_length_i == BIN_LO0;
   assign bin_hit[1] = st_length_i >= BIN_LO1 && st_length_i < BIN_LO2;
   assign bin_hit[2] = st_length_i >= BIN_LO2 && st_length_i < BIN_LO3;
   assign bin_hit[3] = st_length_i >= BIN_LO3 && st_length_i < BIN_LO4;
   assign bin_hit[4] = st_length_i >= BIN_LO4 && st_length_i < BIN_LO5;
   assign bin_hit[5] = st_length_i >= BIN_LO5 && st_length_i <= MAX_STD_LEN;

   // Bus decode
   wire        req       = avs_read_i | avs_write_i;
   wire        wr_take   = avs_write_i & ~wait_q;
   wire [7:0]  page      = avs_address_i[15:8];
   wire [5:0]  slot      = avs_address_i[7:2];
   wire [7:0]  port_pg   = page - PAGE_PORT0;
   wire        in_port   = page >= PAGE_PORT0 && port_pg < 8'(NUM_PORTS) && slot < 6'(SLOTS_PER_PORT);
   wire        in_snap   = page == PAGE_SNAP && slot < 6'(SLOTS_PER_PORT);
   wire        in_class  = page == PAGE_CTRL && slot >= IX_CLASS0 && slot < IX_CLASS0 + 6'(NUM_CLASSES);
   wire [2:0]  class_ix  = 3'(slot - IX_CLASS0);
   wire [PORT_W-1:0] rd_port = port_pg[PORT_W-1:0];
   wire        wr_ctrl   = wr_take && avs_address_i == ADDR_CTRL;
   wire        wr_qsel   = wr_take && avs_address_i == ADDR_QSEL && avs_byteenable_i[0];
   wire        wr_snap   = wr_take && avs_address_i == ADDR_SNAP && avs_byteenable_i[1];
   wire        snap_go   = wr_snap & avs_writedata_i[SNAP_GO_BIT] & avs_byteenable_i[0];
   wire [PORT_W-1:0] snap_port_d = avs_writedata_i[SNAP_PORT_LSB +: PORT_W];
   wire [31:0] ctrl_word = {16'h0000, 8'(hist_tx_q), 6'h00, sym_q, qos_q};
   logic [31:0] rdata_d;

   // [R20] Status type steers transmit and histogram counters
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int i = 0; i < CNT_N; i++) begin
            inc[p][i] = 32'h0000_0000;
         end
         byte_inc[p] = 32'h0000_0000;
         if (st_port_i == PORT_W'(p)) begin
            // [R1] Drop accounting
            inc[p][IX_DISCARD]   = {31'h0, drop_ev};
            // [R2] Good byte total
            byte_inc[p]          = tx_good ? 32'(st_length_i) : 32'h0000_0000;
            // [R3] Broadcast only
            inc[p][IX_BCAST]     = {31'h0, tx_good & st_bcast_i};
            // [R4] Multicast excluding broadcast
            inc[p][IX_MCAST]     = {31'h0, tx_good & st_mcast_i & ~st_bcast_i};
            // [R5] Unicast good packets
            inc[p][IX_UCAST]     = {31'h0, tx_good & ~st_mcast_i & ~st_bcast_i};
            // [R6] Each collision counted
            inc[p][IX_COLL]      = tx_st ? 32'(st_coll_cnt_i) : 32'h0000_0000;
            // [R7] Single versus multiple
            inc[p][IX_ONE_COLL]  = {31'h0, ok_sent & coll_one};
            inc[p][IX_MANY_COLL] = {31'h0, ok_sent & coll_any & ~coll_one};
            // [R8] Half duplex deferral
            inc[p][IX_DEFER]     = {31'h0, tx_st & st_deferred_i & st_half_duplex_i};
            // [R9] Late collisions
            inc[p][IX_LATE]      = {31'h0, tx_st & st_late_coll_i};
            // [R10] Excessive collisions
            inc[p][IX_EXCESS]    = {31'h0, tx_st & st_excess_coll_i};
            // [R11] Pause events
            inc[p][IX_PAUSE]     = {31'h0, tx_st & st_pause_i};
            // [R19] Histogram follows per-port direction
            for (int b = 0; b < NUM_BINS; b++) begin
               inc[p][IX_BIN0 + b] = {31'h0, hist_sel & bin_hit[b]};
            end
         end
         // [R12] Queue-full discards
         inc[p][IX_QFULL]    = {31'h0, queue_full_discard_i[p]};
         // [R15] [R16] Low-power entry events
         inc[p][IX_LPI_EV]   = {31'h0, lp_rise[p]};
         // [R17] Microsecond ticks in low power
         inc[p][IX_LPI_TIME] = {31'h0, lp_state[p] & us_tick};
      end
   end

   // [R22] Plain modular add, each counter alone
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            cnt_q[p]   <= '0;
            bytes_q[p] <= 64'h0;
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            for (int i = 0; i < CNT_N; i++) begin
               cnt_q[p][i] <= cnt_q[p][i] + inc[p][i];
            end
            bytes_q[p] <= bytes_q[p] + 64'(byte_inc[p]);
         end
      end
   end

   // [R13] Class counters watch only the selected port
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int c = 0; c < NUM_CLASSES; c++) begin
            class_q[c] <= 32'h0000_0000;
         end
      end else begin
         for (int c = 0; c < NUM_CLASSES; c++) begin
            if (qos_q && tx_good && st_port_i == qsel_q && st_cos_i == 3'(c)) begin
               class_q[c] <= class_q[c] + 32'h0000_0001;
            end
         end
      end
   end

   // Low-power edge history and microsecond prescaler
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lp_prev_q <= '0;
         us_cnt_q  <= '0;
      end else begin
         lp_prev_q <= lp_state;
         us_cnt_q  <= us_tick ? '0 : us_cnt_q + 1'b1;
      end
   end

   // [R21] Snapshot copy taken at the write edge; live counters continue
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         snap_q       <= '0;
         snap_bytes_q <= 64'h0;
         snap_port_q  <= '0;
      end else if (wr_snap) begin
         snap_port_q <= snap_port_d;
         if (snap_go && snap_port_d < PORT_W'(NUM_PORTS)) begin
            snap_q       <= cnt_q[snap_port_d];
            snap_bytes_q <= bytes_q[snap_port_d];
         end
      end
   end

   // Control registers
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         qos_q     <= QOS_RST;
         sym_q     <= SYM_RST;
         hist_tx_q <= NUM_PORTS'(HIST_RST);
         qsel_q    <= '0;
      end else begin
         if (wr_ctrl && avs_byteenable_i[0]) begin
            qos_q <= avs_writedata_i[CTRL_QOS_BIT];
            sym_q <= avs_writedata_i[CTRL_SYM_BIT];
         end
         if (wr_ctrl && avs_byteenable_i[1]) begin
            hist_tx_q <= avs_writedata_i[CTRL_HIST_LSB +: NUM_PORTS];
         end
         if (wr_qsel) begin
            qsel_q <= avs_writedata_i[PORT_W-1:0];
         end
      end
   end

   // [R18] 45-slot window per port; slots outside our counters read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (avs_address_i == ADDR_CTRL) begin
         rdata_d = ctrl_word;
      end else if (avs_address_i == ADDR_QSEL) begin
         rdata_d = 32'(qsel_q);
      end else if (avs_address_i == ADDR_SNAP) begin
         rdata_d = {16'h0000, 8'(snap_port_q), 8'h00};
      end else if (in_class) begin
         rdata_d = class_q[class_ix];
      end else if (in_port) begin
         rdata_d = slot_read(cnt_q[rd_port], bytes_q[rd_port], slot);
      end else if (in_snap) begin
         rdata_d = slot_read(snap_q, snap_bytes_q, slot);
      end
   end

   // Two-cycle answer; a 64-bit total read live can tear, the snapshot avoids that
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q  <= ~(req & wait_q);
         rdata_q <= (avs_read_i & wait_q) ? rdata_d : rdata_q;
      end
   end

   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o    = rdata_q;

   wire [CNT_N-1:0][31:0] c0 = cnt_q[0];
   wire p0 = st_port_i == '0;

   a_drop_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R1]
      p0 && tx_st && st_mac_err_i && (st_late_coll_i || st_excess_coll_i) && !st_underflow_i
      |=> c0[IX_DISCARD] == $past(c0[IX_DISCARD]))
      else $error("drop counted for collision error");

   a_byte_total: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R2]
      p0 && tx_good |=> bytes_q[0] == $past(bytes_q[0]) + 64'($past(st_length_i)))
      else $error("byte total not advanced by length");

   a_bcast_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R4]
      p0 && tx_good && st_bcast_i |=> c0[IX_MCAST] == $past(c0[IX_MCAST])
      && c0[IX_BCAST] == $past(c0[IX_BCAST]) + 32'h1)
      else $error("broadcast miscounted");

   a_coll_total: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R6]
      p0 && tx_st |=> c0[IX_COLL] == $past(c0[IX_COLL]) + 32'($past(st_coll_cnt_i)))
      else $error("collision total wrong");

   a_many_coll: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R7]
      p0 && ok_sent && st_coll_cnt_i == 5'h02 |=> c0[IX_MANY_COLL] == $past(c0[IX_MANY_COLL]) + 32'h1
      && c0[IX_ONE_COLL] == $past(c0[IX_ONE_COLL]))
      else $error("two collisions not counted as multiple");

   a_defer_half: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R8]
      p0 && tx_st && !st_half_duplex_i |=> $stable(c0[IX_DEFER]))
      else $error("deferral counted in full duplex");

   a_bin_edge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R14]
      p0 && hist_sel && st_length_i == 14'd1023 |=> c0[IX_BIN0 + 4] == $past(c0[IX_BIN0 + 4]) + 32'h1)
      else $error("1023 bytes not in 512-1023 bin");

   a_sym_event: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R16]
      sym_q && tx_low_power_request_i[2] && !rx_low_power_indication_i[2] |=> $stable(cnt_q[2][IX_LPI_EV]))
      else $error("symmetric event without rx indication");

   a_lpi_time: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R17]
      lp_state[1] && us_tick |=> cnt_q[1][IX_LPI_TIME] == $past(cnt_q[1][IX_LPI_TIME]) + 32'h1 ##1
      cnt_q[1][IX_LPI_TIME] == $past(cnt_q[1][IX_LPI_TIME]))
      else $error("low power time not in microsecond steps");

   a_bus_answer: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      req && wait_q |=> !wait_q ##1 wait_q)
      else $error("bus answer not two cycles");

endmodule
`default_nettype wire

// ==== rtl/ptsc_pkg.sv ====
package ptsc_pkg;
   // Port index width; indexes eight ports, but snapshot needs NUM_PORTS of seven or fewer
   localparam int PORT_W        = 3;
   localparam int LEN_W         = 14;
   localparam int COLL_W        = 5;
   localparam int NUM_CLASSES   = 6;
   localparam int NUM_BINS      = 6;
   // Counter slots per port in the address map
   localparam int SLOTS_PER_PORT = 45;
   // Counter slot indices inside one port window
   localparam int IX_DISCARD  = 0;
   localparam int IX_BYTES_LO = 1;
   localparam int IX_BYTES_HI = 2;
   localparam int IX_BCAST    = 3;
   localparam int IX_MCAST    = 4;
   localparam int IX_UCAST    = 5;
   localparam int IX_COLL     = 6;
   localparam int IX_ONE_COLL = 7;
   localparam int IX_MANY_COLL = 8;
   localparam int IX_DEFER    = 9;
   localparam int IX_LATE     = 10;
   localparam int IX_EXCESS   = 11;
   localparam int IX_PAUSE    = 12;
   localparam int IX_QFULL    = 13;
   localparam int IX_BIN0     = 14;
   localparam int IX_LPI_EV   = 20;
   localparam int IX_LPI_TIME = 21;
   localparam int CNT_N       = 22;
   // Histogram bin lower bounds
   localparam logic [13:0] BIN_LO0 = 14'h0040;
   localparam logic [13:0] BIN_LO1 = 14'h0041;
   localparam logic [13:0] BIN_LO2 = 14'h0080;
   localparam logic [13:0] BIN_LO3 = 14'h0100;
   localparam logic [13:0] BIN_LO4 = 14'h0200;
   localparam logic [13:0] BIN_LO5 = 14'h0400;
   // Byte address map
   localparam logic [15:0] ADDR_CTRL      = 16'h0000;
   localparam logic [15:0] ADDR_QSEL      = 16'h0004;
   localparam logic [15:0] ADDR_SNAP      = 16'h0008;
   localparam logic [7:0]  PAGE_CTRL      = 8'h00;
   localparam logic [7:0]  PAGE_PORT0     = 8'h01;
   localparam logic [7:0]  PAGE_SNAP      = 8'h10;
   localparam logic [5:0]  IX_CLASS0      = 6'h04;
   // Control field positions
   localparam int CTRL_QOS_BIT   = 0;
   localparam int CTRL_SYM_BIT   = 1;
   localparam int CTRL_HIST_LSB  = 8;
   localparam int SNAP_GO_BIT    = 0;
   localparam int SNAP_PORT_LSB  = 8;
   // Reset values
   localparam logic       QOS_RST  = 1'b0;
   localparam logic       SYM_RST  = 1'b0;
   localparam logic [7:0] HIST_RST = 8'h00;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS         = 1000;
   localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
   localparam int US_W          = 7;
endpackage

// ==== tb/port_tx_statistics_counters_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_tx_statistics_counters_test;
   import ptsc_pkg::*;
   localparam int NP = 6;
   localparam int IW = NP + 37;
   logic          clk, rst_n, avs_read, avs_write, avs_wait, st_valid;
   logic [15:0]   avs_address, cur_addr;
   logic [31:0]   avs_wdata, avs_rdata, rd;
   logic [3:0]    avs_be;
   logic [35:0]   fld;
   logic [NP-1:0] qfull, lp_tx, lp_rx, hist;
   logic [2:0]    qsel;
   logic          qos_on;
   logic [31:0]   exp_c [NP][CNT_N];
   logic [31:0]   snap_c [CNT_N];
   logic [31:0]   cls [NUM_CLASSES];
   logic [13:0]   corner [13];
   int            seed, errors, compares;

   ptsc_counters #(.NUM_PORTS(NP), .MAX_STD_LEN(14'h5ee)) u_dut (
      .ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(avs_address), .avs_read_i(avs_read),
      .avs_write_i(avs_write), .avs_writedata_i(avs_wdata), .avs_byteenable_i(avs_be),
      .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait), .st_valid_i(st_valid),
      .st_port_i(fld[35:33]), .st_is_tx_i(fld[32]), .st_length_i(fld[31:18]), .st_good_i(fld[17]),
      .st_bcast_i(fld[16]), .st_mcast_i(fld[15]), .st_coll_cnt_i(fld[14:10]), .st_late_coll_i(fld[9]),
      .st_excess_coll_i(fld[8]), .st_deferred_i(fld[7]), .st_half_duplex_i(fld[6]),
      .st_underflow_i(fld[5]), .st_mac_err_i(fld[4]), .st_pause_i(fld[3]), .st_cos_i(fld[2:0]),
      .queue_full_discard_i(qfull), .tx_low_power_request_i(lp_tx), .rx_low_power_indication_i(lp_rx));

   ptsc_mac_model #(.NP(NP)) u_mac (
      .ref_clk_i(clk), .rst_n_i(rst_n), .st_valid_o(st_valid), .st_fields_o(fld),
      .queue_full_discard_o(qfull), .tx_low_power_request_o(lp_tx), .rx_low_power_indication_o(lp_rx));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop();
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("ERROR %0t: watchdog expired", $time);
      report_and_stop();
   end

   task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         errors++;
         $display("ERROR %0t: addr %h read %h expected %h", $time, cur_addr, got, want);
      end
   endtask

   task automatic chk_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      compares++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errors++;
         $display("ERROR %0t: addr %h read %h outside %h..%h", $time, cur_addr, got, lo, hi);
      end
   endtask

   // Request raised just after an edge, held until waitrequest is sampled low at a rising edge
   task automatic bus_xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
                           input logic [3:0] be, output logic [31:0] q);
      int n;
      @(posedge clk);
      cur_addr    = a;
      avs_address <= a;
      avs_read    <= !wr;
      avs_write   <= wr;
      avs_wdata   <= d;
      avs_be      <= be;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_wait !== 1'b0 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("ERROR %0t: no bus answer at %h", $time, a);
      end
      q = avs_rdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   function automatic int bin_of(input logic [13:0] n);
      if (n < 14'h40 || n > 14'h5ee) return -1;
      if (n == 14'h40) return 0;
      if (n < 14'h80) return 1;
      if (n < 14'h100) return 2;
      if (n < 14'h200) return 3;
      return (n < 14'h400) ? 4 : 5;
   endfunction

   task automatic account(input logic [IW-1:0] w);
      logic [2:0]  p;
      logic [63:0] tot;
      int          b;
      p = w[35:33];
      b = bin_of(w[31:18]);
      for (int i = 0; i < NP; i++) if (w[37+i]) exp_c[i][IX_QFULL]++;
      if (!w[36]) return;
      if (b >= 0 && w[32] == hist[p]) exp_c[p][IX_BIN0+b]++;
      if (!w[32]) return;
      if (w[5] || (w[4] && !w[9] && !w[8])) exp_c[p][IX_DISCARD]++;
      if (w[17]) begin
         tot = {exp_c[p][IX_BYTES_HI], exp_c[p][IX_BYTES_LO]} + 64'(w[31:18]);
         {exp_c[p][IX_BYTES_HI], exp_c[p][IX_BYTES_LO]} = tot;
         if (w[16]) exp_c[p][IX_BCAST]++;
         else if (w[15]) exp_c[p][IX_MCAST]++;
         else exp_c[p][IX_UCAST]++;
         if (p == qsel && qos_on) cls[w[2:0]]++;
      end
      exp_c[p][IX_COLL] += 32'(w[14:10]);
      if (w[17] && !w[8] && w[14:10] == 5'h01) exp_c[p][IX_ONE_COLL]++;
      if (w[17] && !w[8] && w[14:10] > 5'h01) exp_c[p][IX_MANY_COLL]++;
      if (w[7] && w[6]) exp_c[p][IX_DEFER]++;
      if (w[9]) exp_c[p][IX_LATE]++;
      if (w[8]) exp_c[p][IX_EXCESS]++;
      if (w[3]) exp_c[p][IX_PAUSE]++;
   endtask

   task automatic send_rand(input int n);
      logic [IW-1:0] w;
      for (int k = 0; k < n; k++) begin
         w = IW'({$random(seed), $random(seed)});
         w[IW-1:37] = w[IW-1:37] & NP'($random(seed));
         w[36] = ($random(seed) % 4) != 0;
         w[35:33] = 3'(unsigned'($random(seed)) % NP);
         w[31:18] = w[0] ? corner[unsigned'($random(seed)) % 13] : 14'(40 + unsigned'($random(seed)) % 1600);
         w[14:10] = 5'(unsigned'($random(seed)) % 17);
         w[2:0] = 3'(unsigned'($random(seed)) % NUM_CLASSES);
         u_mac.push_word(w);
         account(w);
      end
      while (u_mac.pend_q.size() > 0) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask

   task automatic check_port(input logic [15:0] base, input logic [31:0] e [CNT_N]);
      for (int s = 0; s < CNT_N; s++) begin
         bus_xfer(1'b0, base + 16'(4 * s), '0, 4'hf, rd);
         chk_word(rd, e[s]);
      end
      bus_xfer(1'b0, base + 16'h00b0, '0, 4'hf, rd);
      chk_word(rd, 32'h0);
   endtask

   task automatic lpi_check(input logic [15:0] base);
      bus_xfer(1'b0, base + 16'h0050, '0, 4'hf, rd);
      chk_word(rd, 32'h1);
      bus_xfer(1'b0, base + 16'h0054, '0, 4'hf, rd);
      chk_range(rd, 32'h9, 32'hb);
   endtask

   task automatic chk_classes();
      for (int c = 0; c < NUM_CLASSES; c++) begin
         bus_xfer(1'b0, 16'(16'h0010 + 4 * c), '0, 4'hf, rd);
         chk_word(rd, cls[c]);
      end
   endtask

   initial begin
      seed = 32'h0a84f290;
      errors = 0;
      compares = 0;
      qos_on = 1'b1;
      rst_n = 1'b0;
      {avs_address, avs_read, avs_write, avs_wdata, avs_be} = '0;
      corner = '{14'h3f, 14'h40, 14'h41, 14'h7f, 14'h80, 14'hff, 14'h100, 14'h1ff, 14'h200,
                 14'h3ff, 14'h400, 14'h5ee, 14'h5ef};
      foreach (exp_c[p, s]) exp_c[p][s] = '0;
      foreach (cls[c]) cls[c] = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      hist = NP'($random(seed));
      qsel = 3'(unsigned'($random(seed)) % NP);
      bus_xfer(1'b1, ADDR_CTRL, {16'h0, 2'h0, hist, 8'h01}, 4'hf, rd);
      bus_xfer(1'b1, ADDR_QSEL, {29'h0, qsel}, 4'hf, rd);
      send_rand(400);
      for (int p = 0; p < NP; p++) check_port(16'(16'h0100 * (p + 1)), exp_c[p]);
      chk_classes();
      bus_xfer(1'b0, 16'h2000, '0, 4'hf, rd);
      chk_word(rd, 32'h0);
      snap_c = exp_c[3];
      bus_xfer(1'b1, ADDR_SNAP, 32'h0000_0301, 4'h3, rd);
      send_rand(80);
      check_port(16'h1000, snap_c);
      bus_xfer(1'b0, ADDR_SNAP, '0, 4'hf, rd);
      chk_word({24'h0, rd[15:8]}, 32'h3);
      check_port(16'h0400, exp_c[3]);
      u_mac.set_low_power(6'h02, 6'h00);
      repeat (1000) @(posedge clk);
      u_mac.set_low_power(6'h00, 6'h00);
      lpi_check(16'h0200);
      // QoS off from here: class counters must stand still under new traffic
      qos_on = 1'b0;
      bus_xfer(1'b1, ADDR_CTRL, {16'h0, 2'h0, hist, 8'h02}, 4'hf, rd);
      // Lone tx request first, so an asymmetric count would read two
      u_mac.set_low_power(6'h04, 6'h00);
      repeat (200) @(posedge clk);
      u_mac.set_low_power(6'h00, 6'h04);
      repeat (5) @(posedge clk);
      u_mac.set_low_power(6'h04, 6'h04);
      repeat (1000) @(posedge clk);
      u_mac.set_low_power(6'h00, 6'h00);
      lpi_check(16'h0300);
      send_rand(60);
      chk_classes();
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== tb/ptsc_mac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ptsc_mac_model #(
   parameter int NP = 6
) (
   input  wire logic     ref_clk_i,
   input  wire logic     rst_n_i,
   output logic          st_valid_o,
   output logic [35:0]   st_fields_o,
   output logic [NP-1:0] queue_full_discard_o,
   output logic [NP-1:0] tx_low_power_request_o,
   output logic [NP-1:0] rx_low_power_indication_o
);
   logic [NP+36:0] pend_q[$];
   logic [NP+36:0] item;

   task automatic push_word(input logic [NP+36:0] w);
      pend_q.push_back(w);
   endtask

   task automatic set_low_power(input logic [NP-1:0] tx, input logic [NP-1:0] rx);
      tx_low_power_request_o    <= tx;
      rx_low_power_indication_o <= rx;
   endtask

   initial begin
      st_valid_o                = 1'b0;
      st_fields_o               = '0;
      queue_full_discard_o      = '0;
      tx_low_power_request_o    = '0;
      rx_low_power_indication_o = '0;
   end

   // Fields are not held between words; inverting them exposes a counter that samples without valid
   always @(posedge ref_clk_i) begin
      item = '0;
      if (rst_n_i && pend_q.size() > 0) begin
         item = pend_q.pop_front();
      end
      queue_full_discard_o <= item[NP+36:37];
      st_valid_o           <= item[36];
      st_fields_o          <= item[36] ? item[35:0] : ~st_fields_o;
   end
endmodule
`default_nettype wire
